// file: src/spu_top.sv
// serial port: shift-register receive and asynchronous uart with avalon registers
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module spu_top import spu_pkg::*; #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic nrst, // async reset, low
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic rxd, // receive pin
    output logic txd // transmit pin or shift clock
);
    typedef struct packed {
        logic waitq;
        logic [31:0] rdata;
        logic mode;
        logic ren;
        logic filt;
        logic div32;
        logic [15:0] reload;
        logic rx_done;
        logic tx_done;
        logic bit9;
        logic [7:0] rx_buf;
        logic [15:0] t1;
        logic half;
        logic [3:0] txdiv;
        logic txbusy;
        logic [9:0] txsh;
        logic [3:0] txcnt;
        logic txl;
        spu_rx_st_t rxst;
        logic [3:0] rxcnt;
        logic rxprev;
        logic [1:0] rxsmp;
        logic [3:0] rxbit;
        logic [7:0] rxsh;
        logic m0act;
        logic sck;
        logic [3:0] m0cnt;
        logic txd;
    } spu_st_t;

    spu_st_t r_reg, r_next;
    spu_av_req_t req;
    logic ovf, tick, troll, maj, acc, wr, push, pop, clr_rxdone;
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [31:0] rmux;

    assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};
    assign avs_readdata = r_reg.rdata;
    assign avs_waitrequest = r_reg.waitq;
    assign txd = r_reg.txd;

    // buffered transmit words
    spu_fifo #(.W(8), .D(FIFO_DEPTH)) u_txq (
        .clk(clk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(req.writedata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // read data multiplexer
    always_comb begin
        case (req.address)
            SPU_OFS_CTRL: rmux = {28'h0000000, r_reg.div32, r_reg.filt, r_reg.ren, r_reg.mode};
            SPU_OFS_STATUS: rmux = {28'h0000000, r_reg.txbusy, r_reg.bit9, r_reg.tx_done, r_reg.rx_done};
            SPU_OFS_RXDATA: rmux = {24'h000000, r_reg.rx_buf};
            SPU_OFS_BAUD: rmux = {16'h0000, r_reg.reload};
            default: rmux = 32'h00000000;
        endcase
    end

    // bus strobes and baud enables
    assign acc = (req.read || req.write) && r_reg.waitq
        && !(req.write && req.address == SPU_OFS_TXDATA && !fifo_in_ready);
    assign wr = req.write && !r_reg.waitq;
    assign push = wr && req.address == SPU_OFS_TXDATA;
    assign clr_rxdone = wr && req.address == SPU_OFS_STATUS && req.writedata[SPU_ST_RXDONE];
    assign ovf = (r_reg.t1 == r_reg.reload);
    assign tick = ovf && (!r_reg.div32 || r_reg.half);
    assign troll = tick && r_reg.txdiv == SPU_SLICE_LAST;
    assign maj = (r_reg.rxsmp[0] & r_reg.rxsmp[1]) | (r_reg.rxsmp[0] & rxd) | (r_reg.rxsmp[1] & rxd);
    assign pop = r_reg.mode && !r_reg.txbusy && fifo_out_valid;

    // next state of the whole port
    always_comb begin
        r_next = r_reg;
        // one-cycle bus answer, stalled while a transmit data write finds the fifo full
        r_next.waitq = 1'b1;
        if (acc) begin
            r_next.waitq = 1'b0;
            r_next.rdata = rmux;
        end
        if (wr && req.address == SPU_OFS_CTRL) begin
            r_next.mode = req.writedata[SPU_CTRL_MODE];
            r_next.ren = req.writedata[SPU_CTRL_REN];
            r_next.filt = req.writedata[SPU_CTRL_FILT];
            r_next.div32 = req.writedata[SPU_CTRL_DIV32];
        end
        if (wr && req.address == SPU_OFS_BAUD) begin
            r_next.reload = req.writedata[15:0];
        end
        // write one to clear; later hardware sets win
        if (clr_rxdone) begin
            r_next.rx_done = 1'b0;
        end
        if (wr && req.address == SPU_OFS_STATUS && req.writedata[SPU_ST_TXDONE]) begin
            r_next.tx_done = 1'b0;
        end
        // overflow timer and 16/32 split
        if (ovf) begin
            r_next.t1 = 16'h0000;
            r_next.half = !r_reg.half;
        end else begin
            r_next.t1 = r_reg.t1 + 16'h0001;
        end
        // transmit slice counter runs free
        if (tick) begin
            r_next.txdiv = r_reg.txdiv + 4'h1;
        end
        // transmitter: load on pop, shift on rollover
        if (pop) begin
            r_next.txbusy = 1'b1;
            r_next.txsh = {1'b1, fifo_out_data, 1'b0};
            r_next.txcnt = 4'h0;
        end else if (r_reg.txbusy && troll) begin
            if (r_reg.txcnt == SPU_TX_END) begin
                r_next.txbusy = 1'b0;
            end else begin
                r_next.txl = r_reg.txsh[0];
                r_next.txsh = {1'b1, r_reg.txsh[9:1]};
                r_next.txcnt = r_reg.txcnt + 4'h1;
                if (r_reg.txcnt == SPU_STOP_IDX) begin
                    r_next.tx_done = 1'b1;
                end
            end
        end
        // asynchronous receiver
        if (!r_reg.mode || !r_reg.ren) begin
            r_next.rxst = RX_HUNT;
            r_next.rxprev = 1'b1;
        end else if (tick) begin
            case (r_reg.rxst)
                RX_HUNT: begin
                    r_next.rxprev = rxd;
                    if (r_reg.rxprev && !rxd) begin
                        r_next.rxst = RX_BITS;
                        r_next.rxcnt = 4'h0;
                        r_next.rxbit = 4'h0;
                    end
                end
                RX_BITS: begin
                    r_next.rxcnt = r_reg.rxcnt + 4'h1;
                    if (r_reg.rxcnt == SPU_SMP_A) begin
                        r_next.rxsmp[0] = rxd;
                    end
                    if (r_reg.rxcnt == SPU_SMP_B) begin
                        r_next.rxsmp[1] = rxd;
                    end
                    if (r_reg.rxcnt == SPU_SMP_C) begin
                        r_next.rxprev = maj;
                        if (r_reg.rxbit == 4'h0 && maj) begin
                            r_next.rxst = RX_HUNT;
                        end else if (r_reg.rxbit == SPU_STOP_IDX) begin
                            r_next.rxst = RX_HUNT;
                            if (!r_reg.rx_done && (!r_reg.filt || maj)) begin
                                r_next.bit9 = maj;
                                r_next.rx_buf = r_reg.rxsh;
                                r_next.rx_done = 1'b1;
                            end
                        end else begin
                            if (r_reg.rxbit != 4'h0) begin
                                r_next.rxsh = {maj, r_reg.rxsh[7:1]};
                            end
                            r_next.rxbit = r_reg.rxbit + 4'h1;
                        end
                    end
                end
                default: r_next.rxst = RX_HUNT;
            endcase
        end
        // shift-register receive, clock driven on the transmit pin
        if (r_reg.mode) begin
            r_next.m0act = 1'b0;
            r_next.sck = 1'b1;
            r_next.m0cnt = 4'h0;
        end else if (!r_reg.m0act) begin
            r_next.sck = 1'b1;
            if (r_reg.ren && !r_reg.rx_done) begin
                r_next.m0act = 1'b1;
            end
        end else if (tick) begin
            if (r_reg.sck) begin
                r_next.sck = 1'b0;
            end else begin
                r_next.sck = 1'b1;
                r_next.rxsh = {rxd, r_reg.rxsh[7:1]};
                r_next.m0cnt = r_reg.m0cnt + 4'h1;
                if (r_reg.m0cnt == SPU_M0_LAST) begin
                    r_next.m0act = 1'b0;
                    r_next.m0cnt = 4'h0;
                    r_next.rx_buf = {rxd, r_reg.rxsh[7:1]};
                    r_next.rx_done = 1'b1;
                end
            end
        end
        r_next.txd = r_reg.mode ? r_next.txl : r_next.sck;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.waitq <= 1'b1;
            r_reg.mode <= SPU_MODE_RST;
            r_reg.reload <= SPU_BAUD_RST;
            r_reg.txl <= 1'b1;
            r_reg.txsh <= 10'h3FF;
            r_reg.rxst <= RX_HUNT;
            r_reg.rxprev <= 1'b1;
            r_reg.sck <= 1'b1;
            r_reg.txd <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // checks on the port behaviour
    m0_start_a: assert property ($rose(r_reg.m0act) |-> $past(r_reg.ren && !r_reg.rx_done && !r_reg.mode))
        else $error("shift receive started while disabled");
    m0_edge_a: assert property ($changed(r_reg.m0cnt) |-> $rose(r_reg.sck))
        else $error("shift bit counted off a rising clock");
    m0_done_a: assert property (tick && r_reg.m0act && !r_reg.sck && r_reg.m0cnt == 4'h7 && !r_reg.mode
        |=> r_reg.rx_done && !r_reg.m0act)
        else $error("shift receive did not finish");
    tx_start_a: assert property (r_reg.mode && r_reg.txbusy && r_reg.txcnt == 4'h1 |-> !r_reg.txd)
        else $error("start bit not low");
    tx_stop_a: assert property (r_reg.mode && r_reg.txbusy && r_reg.txcnt == 4'hA |-> r_reg.txd)
        else $error("stop bit not high");
    tick_rate_a: assert property (tick |-> ovf && (!r_reg.div32 || r_reg.half))
        else $error("baud tick off the overflow rate");
    tx_align_a: assert property ($changed(r_reg.txl) |-> $past(troll))
        else $error("transmit line moved off a rollover");
    tx_done_a: assert property (troll && r_reg.txbusy && !pop && r_reg.txcnt == 4'h9 |=> r_reg.tx_done)
        else $error("transmit flag missing after stop bit");
    rx_align_a: assert property (r_reg.mode && r_reg.ren && tick && r_reg.rxst == RX_HUNT && r_reg.rxprev && !rxd
        |=> r_reg.rxst == RX_BITS && r_reg.rxcnt == 4'h0)
        else $error("slice counter not reset on edge");
    rx_abort_a: assert property (r_reg.mode && r_reg.ren && tick && r_reg.rxst == RX_BITS
        && r_reg.rxcnt == 4'h9 && r_reg.rxbit == 4'h0 && maj |=> r_reg.rxst == RX_HUNT)
        else $error("bad start bit not aborted");
    rx_reject_a: assert property (r_reg.mode && r_reg.ren && tick && r_reg.rxst == RX_BITS
        && r_reg.rxcnt == 4'h9 && r_reg.rxbit == 4'h9 && r_reg.rx_done |=> $stable(r_reg.rx_buf))
        else $error("frame stored while flag set");
    rxdone_hold_a: assert property ($fell(r_reg.rx_done) |-> $past(clr_rxdone))
        else $error("receive flag cleared by hardware");
endmodule

// file: src/spu_pkg.sv
// constants and types for the serial port block
package spu_pkg;
    // register byte offsets
    localparam logic [4:0] SPU_OFS_CTRL = 5'h00;
    localparam logic [4:0] SPU_OFS_STATUS = 5'h04;
    localparam logic [4:0] SPU_OFS_TXDATA = 5'h08;
    localparam logic [4:0] SPU_OFS_RXDATA = 5'h0C;
    localparam logic [4:0] SPU_OFS_BAUD = 5'h10;
    // control field positions
    localparam int SPU_CTRL_MODE = 0;
    localparam int SPU_CTRL_REN = 1;
    localparam int SPU_CTRL_FILT = 2;
    localparam int SPU_CTRL_DIV32 = 3;
    // status field positions
    localparam int SPU_ST_RXDONE = 0;
    localparam int SPU_ST_TXDONE = 1;
    localparam int SPU_ST_BIT9 = 2;
    localparam int SPU_ST_BUSY = 3;
    // reset values
    localparam logic [15:0] SPU_BAUD_RST = 16'h0000;
    localparam logic SPU_MODE_RST = 1'h0;
    // bit timing counts
    localparam logic [3:0] SPU_SLICE_LAST = 4'hF;
    localparam logic [3:0] SPU_SMP_A = 4'h7;
    localparam logic [3:0] SPU_SMP_B = 4'h8;
    localparam logic [3:0] SPU_SMP_C = 4'h9;
    localparam logic [3:0] SPU_STOP_IDX = 4'h9;
    localparam logic [3:0] SPU_TX_END = 4'hA;
    localparam logic [3:0] SPU_M0_LAST = 4'h7;

    typedef enum logic {RX_HUNT, RX_BITS} spu_rx_st_t;

    // avalon request bundle
    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } spu_av_req_t;
endpackage

// file: src/spu_fifo.sv
// transmit data fifo with valid and ready on both sides
`timescale 1ns/10ps
module spu_fifo import spu_pkg::*; #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, low
    input wire logic in_valid, // push request
    output logic in_ready, // room available
    input wire logic [W-1:0] in_data, // push data
    output logic out_valid, // data available
    input wire logic out_ready, // pop request
    output logic [W-1:0] out_data // head word
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } spu_fifo_st_t;

    spu_fifo_st_t r_reg, r_next;
    logic [W-1:0] mem [D];
    logic push, pop;

    // flags from pointer compare
    assign out_valid = (r_reg.wp != r_reg.rp);
    assign in_ready = !((r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]));
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[r_reg.rp[AW-1:0]];

    // pointer update
    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[r_reg.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// file: verification/spu_peer.sv
// far-side model: external shift register and remote uart
`timescale 1ns/10ps
module spu_peer (
    input wire logic clk, // system clock
    input wire logic txd, // line or shift clock from the block
    input wire logic shift_mode, // act as external shift register
    input wire logic [7:0] bit_clks, // clocks per bit on the line
    output logic rxd, // line into the block
    output logic [9:0] got_frame, // last frame seen on txd
    output int got_cnt // frames seen so far
);
    logic [7:0] sh_data;
    int sh_cnt;
    logic txd_q;
    logic [9:0] f;
    initial begin
        rxd = 1'b1;
        got_cnt = 0;
        got_frame = 10'h000;
        sh_data = 8'h00;
        sh_cnt = 9;
        txd_q = 1'b1;
    end
    // one async frame, optionally after a short false start
    task automatic send_frame(input logic [7:0] d, input logic stp, input logic noise);
        logic [9:0] fr;
        fr = {stp, d, 1'b0};
        if (noise) begin
            rxd <= 1'b0;
            repeat (bit_clks / 4) @(posedge clk);
            rxd <= 1'b1;
            repeat (int'(bit_clks) * 2) @(posedge clk);
        end
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (bit_clks) @(posedge clk);
        end
        if (!stp) begin
            rxd <= 1'b1;
            @(posedge clk);
        end
    endtask
    task automatic load_shift(input logic [7:0] d);
        sh_data = d;
        sh_cnt = 0;
    endtask
    // shift source: next bit after each falling shift clock, noise once hold is over
    always @(posedge clk) begin
        txd_q <= txd;
        if (!shift_mode) begin
            if (sh_cnt != 10) begin
                rxd <= 1'b1;
                sh_cnt <= 10;
            end
        end else if (txd_q && !txd && sh_cnt < 8) begin
            rxd <= sh_data[sh_cnt[2:0]];
            sh_cnt <= sh_cnt + 1;
        end else if (sh_cnt == 8 && !txd_q && txd) begin
            sh_cnt <= 9;
        end else if (sh_cnt >= 9) begin
            rxd <= ~rxd;
        end
    end
    // uart monitor: sample each bit in its middle after a start edge
    initial forever begin
        @(negedge txd);
        if (!shift_mode) begin
            repeat (bit_clks / 2) @(posedge clk);
            for (int i = 0; i < 10; i++) begin
                f[i] = txd;
                if (i < 9) repeat (bit_clks) @(posedge clk);
            end
            got_frame <= f;
            got_cnt <= got_cnt + 1;
        end
    end
endmodule

// file: verification/spu_top_bench.sv
// self-checking bench for the serial port block
`timescale 1ns/10ps
module spu_top_bench import spu_pkg::*;;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, rxd, txd, peer_shift;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, s;
    logic [7:0] bit_clks;
    logic [9:0] got_frame;
    logic [9:0] q[$];
    int got_cnt, error_cnt, checked, cyc, t0, n;
    spu_top #(.FIFO_DEPTH(32)) u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));
    spu_peer u_peer (.clk(clk), .txd(txd), .shift_mode(peer_shift), .bit_clks(bit_clks), .rxd(rxd),
        .got_frame(got_frame), .got_cnt(got_cnt));
    // 50 MHz clock and a free cycle count
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd_d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 5000);
        rd_d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 5000) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        acc(1'b1, a, d, dummy);
    endtask
    task automatic wait_st(input int b);
        int k;
        k = 0;
        s = 32'h0;
        while (s[b] !== 1'b1 && k < 3000) begin
            acc(1'b0, SPU_OFS_STATUS, 32'h0, s);
            k++;
        end
        if (k >= 3000) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
    endtask
    task automatic wait_q();
        int k;
        k = 0;
        while (q.size() != 0 && k < 40000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 40000) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, s);
        chk(s, exp);
    endtask
    // each frame seen on txd must match the oldest queued byte
    always @(got_cnt) #1 begin
        if (q.size() == 0) chk({22'h0, got_frame}, 32'hFFFFFFFF);
        else chk({22'h0, got_frame}, {22'h0, q.pop_front()});
    end
    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        peer_shift = 1'b1;
        bit_clks = 8'd64;
        cyc = 0;
        error_cnt = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // reset values, unmapped write ignored
        wr(5'h14, 32'hFFFFFFFF);
        for (int i = 0; i < 6; i++) rd_chk(5'(i * 4), 32'h0);
        // shift mode stays idle until receive is enabled
        u_peer.load_shift(8'hA5);
        wr(SPU_OFS_BAUD, 32'h3);
        n = 0;
        repeat (60) begin
            @(posedge clk);
            if (txd !== 1'b1) n++;
        end
        chk(n, 0);
        wr(SPU_OFS_CTRL, 32'h2);
        wait_st(SPU_ST_RXDONE);
        rd_chk(SPU_OFS_RXDATA, 32'hA5);
        n = 0;
        repeat (100) begin
            @(posedge clk);
            if (txd !== 1'b1) n++;
        end
        chk(n, 0);
        rd_chk(SPU_OFS_STATUS, 32'h1);
        u_peer.load_shift(8'h3C);
        wr(SPU_OFS_STATUS, 32'h1);
        wait_st(SPU_ST_RXDONE);
        rd_chk(SPU_OFS_RXDATA, 32'h3C);
        // disable receive first so no shift clock restarts on the clear
        wr(SPU_OFS_CTRL, 32'h0);
        wr(SPU_OFS_STATUS, 32'h1);
        // async transmit: start on a rollover, flag nine rollovers on
        peer_shift <= 1'b0;
        wr(SPU_OFS_CTRL, 32'h3);
        q.push_back({1'b1, 8'h55, 1'b0});
        wr(SPU_OFS_TXDATA, 32'h55);
        n = 0;
        while (txd === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n <= 68), 32'h1);
        t0 = cyc;
        wait_st(SPU_ST_TXDONE);
        chk(32'(cyc - t0 >= 570 && cyc - t0 <= 590), 32'h1);
        wait_q();
        wr(SPU_OFS_STATUS, 32'h2);
        // divide by 32 doubles the bit time
        bit_clks <= 8'd128;
        wr(SPU_OFS_CTRL, 32'hB);
        q.push_back({1'b1, 8'h96, 1'b0});
        wr(SPU_OFS_TXDATA, 32'h96);
        wait_q();
        bit_clks <= 8'd64;
        wr(SPU_OFS_CTRL, 32'h3);
        // overfill the fifo so writes stall, then drain it
        for (int i = 0; i < 35; i++) begin
            q.push_back({1'b1, 8'(i * 7 + 3), 1'b0});
            wr(SPU_OFS_TXDATA, 32'(i * 7 + 3));
        end
        wait_q();
        repeat (200) @(posedge clk);
        acc(1'b0, SPU_OFS_STATUS, 32'h0, s);
        chk(s & 32'hB, 32'h2);
        // async receive: accept, drop while flag set, filter, false start
        wr(SPU_OFS_STATUS, 32'h3);
        u_peer.send_frame(8'h5A, 1'b1, 1'b0);
        wait_st(SPU_ST_RXDONE);
        rd_chk(SPU_OFS_STATUS, 32'h5);
        rd_chk(SPU_OFS_RXDATA, 32'h5A);
        u_peer.send_frame(8'h11, 1'b1, 1'b0);
        rd_chk(SPU_OFS_RXDATA, 32'h5A);
        wr(SPU_OFS_STATUS, 32'h1);
        wr(SPU_OFS_CTRL, 32'h7);
        u_peer.send_frame(8'h22, 1'b0, 1'b0);
        repeat (20) @(posedge clk);
        rd_chk(SPU_OFS_STATUS, 32'h4);
        u_peer.send_frame(8'h44, 1'b1, 1'b0);
        wait_st(SPU_ST_RXDONE);
        rd_chk(SPU_OFS_RXDATA, 32'h44);
        wr(SPU_OFS_STATUS, 32'h1);
        wr(SPU_OFS_CTRL, 32'h3);
        u_peer.send_frame(8'h33, 1'b1, 1'b1);
        wait_st(SPU_ST_RXDONE);
        rd_chk(SPU_OFS_RXDATA, 32'h33);
        wr(SPU_OFS_STATUS, 32'h1);
        // back-to-back frames, flag cleared between them
        fork
            begin
                u_peer.send_frame(8'h81, 1'b1, 1'b0);
                u_peer.send_frame(8'h7E, 1'b1, 1'b0);
            end
            begin
                wait_st(SPU_ST_RXDONE);
                rd_chk(SPU_OFS_RXDATA, 32'h81);
                wr(SPU_OFS_STATUS, 32'h1);
                wait_st(SPU_ST_RXDONE);
                rd_chk(SPU_OFS_RXDATA, 32'h7E);
            end
        join
        stop_test();
    end
endmodule
